// ==== verilog/ebt_pkg.sv ====
// package: constants, modes and carrier types of the 8-bit timer core
package ebt_pkg;

   // =========================================
   // counter extremes and reset values
   localparam logic [7:0] EBT_BOTTOM      = 8'h00;
   localparam logic [7:0] EBT_MAX         = 8'hff;
   localparam logic [7:0] EBT_CNT_RST     = 8'h00;
   localparam logic [7:0] EBT_CMP_RST     = 8'h00;
   localparam logic [2:0] EBT_FLAG_RST    = 3'h0;
   localparam logic [2:0] EBT_MASK_RST    = 3'h0;

   // =========================================
   // flag and mask bit positions
   localparam int EBT_BIT_OVF = 0;
   localparam int EBT_BIT_MA  = 1;
   localparam int EBT_BIT_MB  = 2;

   // =========================================
   // prescaler: divider taps, terminal values one below the system clocks per tick
   localparam int           EBT_PRE_W     = 10;
   localparam logic [9:0]   EBT_DIV8      = 10'h007;
   localparam logic [9:0]   EBT_DIV64     = 10'h03f;
   localparam logic [9:0]   EBT_DIV256    = 10'h0ff;
   localparam logic [9:0]   EBT_DIV1024   = 10'h3ff;

   // =========================================
   // tick source selection
   typedef enum logic [2:0] {
      EBT_CS_STOP    = 3'h0,
      EBT_CS_DIV1    = 3'h1,
      EBT_CS_DIV8    = 3'h2,
      EBT_CS_DIV64   = 3'h3,
      EBT_CS_DIV256  = 3'h4,
      EBT_CS_DIV1024 = 3'h5,
      EBT_CS_EXT_FALL = 3'h6,
      EBT_CS_EXT_RISE = 3'h7
   } ebt_cs_t;

   // waveform modes (mode code bit 2, and the clear mode, select compare A as top)
   typedef enum logic [2:0] {
      EBT_WM_NORMAL   = 3'h0,
      EBT_WM_PC_MAX   = 3'h1,
      EBT_WM_CLEAR    = 3'h2,
      EBT_WM_FAST_MAX = 3'h3,
      EBT_WM_RSV4     = 3'h4,
      EBT_WM_PC_A     = 3'h5,
      EBT_WM_RSV6     = 3'h6,
      EBT_WM_FAST_A   = 3'h7
   } ebt_wm_t;

   // compare output action
   typedef enum logic [1:0] {
      EBT_CO_OFF    = 2'h0,
      EBT_CO_TOGGLE = 2'h1,
      EBT_CO_CLEAR  = 2'h2,
      EBT_CO_SET    = 2'h3
   } ebt_co_t;

   // processor write strobes with data
   typedef struct packed {
      logic       cnt_we;
      logic       cmp_a_we;
      logic       cmp_b_we;
      logic       mask_we;
      logic       flag_we;
      logic [7:0] wdata;
   } ebt_wr_t;

   // processor configuration
   typedef struct packed {
      ebt_cs_t    clk_sel;
      ebt_wm_t    wave_mode;
      ebt_co_t    out_mode_a;
      ebt_co_t    out_mode_b;
   } ebt_cfg_t;

endpackage

// ==== verilog/ebt_prescaler.sv ====
// file: tick source selection with prescaler and external edge detection
`timescale 1ns/1ps
module ebt_prescaler (
   input  wire logic           clk_sys_i,
   input  wire logic           rstn_i,
   input  wire ebt_pkg::ebt_cs_t clk_sel_i,
   input  wire logic           ext_count_pin_i,
   output logic                timer_tick_o
);
   import ebt_pkg::*;

   logic [9:0] pre_reg;
   logic [9:0] pre_next;
   logic       ext_s1_reg;
   logic       ext_s2_reg;
   logic       ext_d_reg;
   wire        ext_rise;
   wire        ext_fall;

   // =========================================
   // free-running divider; each tap fires once per wrap of its field
   assign pre_next = pre_reg + 10'h001;
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) pre_reg <= 10'h000;
      else         pre_reg <= pre_next;
   end

   // two-stage synchroniser, then edge detect off the second stage only
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         ext_s1_reg <= 1'b0;
         ext_s2_reg <= 1'b0;
         ext_d_reg  <= 1'b0;
      end else begin
         ext_s1_reg <= ext_count_pin_i;
         ext_s2_reg <= ext_s1_reg;
         ext_d_reg  <= ext_s2_reg;
      end
   end
   assign ext_rise = ext_s2_reg & ~ext_d_reg;
   assign ext_fall = ~ext_s2_reg & ext_d_reg;

   // source and edge choice; stop yields no tick at all
   always_comb begin
      case (clk_sel_i)
         EBT_CS_STOP:     timer_tick_o = 1'b0;
         EBT_CS_DIV1:     timer_tick_o = 1'b1;
         EBT_CS_DIV8:     timer_tick_o = (pre_reg[2:0] == EBT_DIV8[2:0]);
         EBT_CS_DIV64:    timer_tick_o = (pre_reg[5:0] == EBT_DIV64[5:0]);
         EBT_CS_DIV256:   timer_tick_o = (pre_reg[7:0] == EBT_DIV256[7:0]);
         EBT_CS_DIV1024:  timer_tick_o = (pre_reg == EBT_DIV1024);
         EBT_CS_EXT_FALL: timer_tick_o = ext_fall;
         EBT_CS_EXT_RISE: timer_tick_o = ext_rise;
         default:         timer_tick_o = 1'b0;
      endcase
   end
endmodule

// ==== verilog/ebt_timer.sv ====
// file: 8-bit timer/counter core with two compare units and pwm
`timescale 1ns/1ps

module ebt_timer (
   input  wire logic              clk_sys_i,
   input  wire logic              rstn_i,
   input  wire ebt_pkg::ebt_wr_t  wr_i,
   input  wire ebt_pkg::ebt_cfg_t cfg_i,
   input  wire logic [2:0]        irq_ack_i,
   input  wire logic              ext_count_pin_i,
   output logic [7:0]             count_value_o,
   output logic [7:0]             compare_value_a_o,
   output logic [7:0]             compare_value_b_o,
   output logic [2:0]             timer_flag_reg_o,
   output logic [2:0]             timer_irq_mask_reg_o,
   output logic [2:0]             irq_req_o,
   output logic                   compare_out_a_o,
   output logic                   compare_out_b_o
);
   import ebt_pkg::*;

   logic [7:0] count_value_reg;
   logic [7:0] count_value_next;
   logic [7:0] buf_a_reg;
   logic [7:0] buf_b_reg;
   logic [7:0] act_a_reg;
   logic [7:0] act_b_reg;
   logic [2:0] flag_reg;
   logic [2:0] flag_next;
   logic [2:0] mask_reg;
   logic       dir_down_reg;
   logic       dir_down_next;
   logic       oc_a_reg;
   logic       oc_b_reg;
   logic       oc_a_next;
   logic       oc_b_next;
   logic       blk_reg;
   logic       pend_a_reg;
   logic       pend_b_reg;
   logic       pend_ovf_reg;
   wire        timer_tick;

   // =========================================
   // tick source
   ebt_prescaler u_pre (
      .clk_sys_i       (clk_sys_i),
      .rstn_i          (rstn_i),
      .clk_sel_i       (cfg_i.clk_sel),
      .ext_count_pin_i (ext_count_pin_i),
      .timer_tick_o    (timer_tick)
   );

   // =========================================
   // mode decode
   wire is_pc    = (cfg_i.wave_mode == EBT_WM_PC_MAX) | (cfg_i.wave_mode == EBT_WM_PC_A);
   wire is_fast  = (cfg_i.wave_mode == EBT_WM_FAST_MAX) | (cfg_i.wave_mode == EBT_WM_FAST_A);
   wire is_clear = (cfg_i.wave_mode == EBT_WM_CLEAR);
   wire is_pwm   = is_pc | is_fast;
   wire top_is_a = is_clear | cfg_i.wave_mode[2];
   wire [7:0] top_val = top_is_a ? act_a_reg : EBT_MAX;
   wire at_bottom = (count_value_reg == EBT_BOTTOM);
   wire at_max    = (count_value_reg == EBT_MAX);
   wire at_top    = (count_value_reg == top_val);

   // comparators run every cycle on the active stage
   wire match_a = (count_value_reg == act_a_reg);
   wire match_b = (count_value_reg == act_b_reg);

   // =========================================
   // counter next value: write first, then clear, then count
   always_comb begin
      count_value_next = count_value_reg;
      dir_down_next    = dir_down_reg;
      if (wr_i.cnt_we) begin
         count_value_next = wr_i.wdata;
      end else if (timer_tick) begin
         if (is_pc) begin
            // dual slope: turn at top and bottom
            if (!dir_down_reg && at_top) begin
               dir_down_next    = 1'b1;
               count_value_next = count_value_reg - 8'h01;
            end else if (dir_down_reg && at_bottom) begin
               dir_down_next    = 1'b0;
               count_value_next = count_value_reg + 8'h01;
            end else if (dir_down_reg) begin
               count_value_next = count_value_reg - 8'h01;
            end else begin
               count_value_next = count_value_reg + 8'h01;
            end
         end else if ((is_clear | is_fast) && at_top) begin
            count_value_next = EBT_BOTTOM;
            dir_down_next    = 1'b0;
         end else begin
            count_value_next = count_value_reg + 8'h01;
            dir_down_next    = 1'b0;
         end
      end
   end

   // overflow event: max in normal/clear, top in fast, bottom turn in phase correct
   wire ovf_evt = timer_tick & ~wr_i.cnt_we &
                  (is_pc ? (dir_down_reg & at_bottom) : (is_fast ? at_top : at_max));

   // =========================================
   // counter, direction and match-blocking state
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         count_value_reg <= EBT_CNT_RST;
         dir_down_reg    <= 1'b0;
         blk_reg         <= 1'b0;
      end else begin
         count_value_reg <= count_value_next;
         dir_down_reg    <= dir_down_next;
         // a count write hides matches until the next tick has passed
         if (wr_i.cnt_we)     blk_reg <= 1'b1;
         else if (timer_tick) blk_reg <= 1'b0;
      end
   end

   // =========================================
   // compare buffers: pwm modes load active stage at top or bottom
   wire upd_pt = timer_tick & (is_pc ? at_top : at_bottom);
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         buf_a_reg <= EBT_CMP_RST;
         buf_b_reg <= EBT_CMP_RST;
         act_a_reg <= EBT_CMP_RST;
         act_b_reg <= EBT_CMP_RST;
      end else begin
         if (wr_i.cmp_a_we) buf_a_reg <= wr_i.wdata;
         if (wr_i.cmp_b_we) buf_b_reg <= wr_i.wdata;
         if (!is_pwm) begin
            // direct access; odd pulses are harmless outside pwm
            if (wr_i.cmp_a_we) act_a_reg <= wr_i.wdata;
            if (wr_i.cmp_b_we) act_b_reg <= wr_i.wdata;
         end else if (upd_pt) begin
            act_a_reg <= buf_a_reg;
            act_b_reg <= buf_b_reg;
         end
      end
   end

   // =========================================
   // match latched, flag set on the following tick
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         pend_a_reg   <= 1'b0;
         pend_b_reg   <= 1'b0;
         pend_ovf_reg <= 1'b0;
      end else begin
         if (timer_tick) begin
            pend_a_reg <= 1'b0;
            pend_b_reg <= 1'b0;
         end
         if (match_a & ~blk_reg & ~wr_i.cnt_we) pend_a_reg <= 1'b1;
         if (match_b & ~blk_reg & ~wr_i.cnt_we) pend_b_reg <= 1'b1;
         pend_ovf_reg <= ovf_evt;
      end
   end

   wire set_a = pend_a_reg & timer_tick;
   wire set_b = pend_b_reg & timer_tick;
   wire [2:0] set_vec = {set_b, set_a, pend_ovf_reg};
   wire [2:0] clr_vec = irq_ack_i | ({3{wr_i.flag_we}} & wr_i.wdata[2:0]);

   // set beats clear so no event is lost in a clearing cycle
   assign flag_next = (flag_reg & ~clr_vec) | set_vec;
   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         flag_reg <= EBT_FLAG_RST;
         mask_reg <= EBT_MASK_RST;
      end else begin
         flag_reg <= flag_next;
         if (wr_i.mask_we) mask_reg <= wr_i.wdata[2:0];
      end
   end

   // =========================================
   // waveform generator
   function automatic logic wave_act(input ebt_co_t m, input logic cur, input logic pc_mode,
                                     input logic fast_mode, input logic down);
      logic r;
      r = cur;
      case (m)
         EBT_CO_OFF:    r = cur;
         EBT_CO_TOGGLE: r = (pc_mode | fast_mode) ? cur : ~cur;
         EBT_CO_CLEAR:  r = pc_mode ? down : 1'b0;
         EBT_CO_SET:    r = pc_mode ? ~down : 1'b1;
         default:       r = cur;
      endcase
      return r;
   endfunction

   // fast pwm sets/clears the opposite level at bottom
   always_comb begin
      oc_a_next = oc_a_reg;
      oc_b_next = oc_b_reg;
      if (set_a) oc_a_next = wave_act(cfg_i.out_mode_a, oc_a_reg, is_pc, is_fast, dir_down_reg);
      else if (is_fast && timer_tick && at_bottom && cfg_i.out_mode_a[1])
         oc_a_next = ~cfg_i.out_mode_a[0];
      if (set_b) oc_b_next = wave_act(cfg_i.out_mode_b, oc_b_reg, is_pc, is_fast, dir_down_reg);
      else if (is_fast && timer_tick && at_bottom && cfg_i.out_mode_b[1])
         oc_b_next = ~cfg_i.out_mode_b[0];
   end

   always_ff @(posedge clk_sys_i) begin
      if (!rstn_i) begin
         oc_a_reg <= 1'b0;
         oc_b_reg <= 1'b0;
      end else begin
         oc_a_reg <= oc_a_next;
         oc_b_reg <= oc_b_next;
      end
   end

   // =========================================
   // outputs
   assign count_value_o        = count_value_reg;
   assign compare_value_a_o    = is_pwm ? buf_a_reg : act_a_reg;
   assign compare_value_b_o    = is_pwm ? buf_b_reg : act_b_reg;
   assign timer_flag_reg_o     = flag_reg;
   assign timer_irq_mask_reg_o = mask_reg;
   assign irq_req_o            = flag_reg & mask_reg;
   assign compare_out_a_o      = oc_a_reg;
   assign compare_out_b_o      = oc_b_reg;

   // =========================================
   // assertions
   a_write_priority: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      wr_i.cnt_we |=> count_value_reg == $past(wr_i.wdata)) else $error("count write lost");
   a_stopped_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (cfg_i.clk_sel == EBT_CS_STOP && !wr_i.cnt_we) |=> $stable(count_value_reg))
      else $error("counter moved while stopped");
   a_irq_gate: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      irq_req_o == (timer_flag_reg_o & timer_irq_mask_reg_o)) else $error("irq gating wrong");
   a_flag_a_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      set_a |=> flag_reg[EBT_BIT_MA]) else $error("match a flag not set");
   a_flag_b_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (timer_tick && pend_b_reg) |=> flag_reg[EBT_BIT_MB]) else $error("match b flag not set");
   a_flag_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (irq_ack_i[EBT_BIT_OVF] && !pend_ovf_reg) |=> !flag_reg[EBT_BIT_OVF]) else $error("flag not cleared");
   a_clear_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_clear && timer_tick && at_top && !wr_i.cnt_we) |=> count_value_reg == EBT_BOTTOM)
      else $error("no clear at top");
   a_direct_cmp: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!is_pwm && wr_i.cmp_a_we) |=> act_a_reg == $past(wr_i.wdata)) else $error("direct write missing");
   a_pc_down: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_pc && timer_tick && dir_down_reg && !at_bottom && !wr_i.cnt_we)
      |=> count_value_reg == $past(count_value_reg) - 8'h01) else $error("down count wrong");
   c_ovf: cover property (@(posedge clk_sys_i) ovf_evt);
   c_match_a: cover property (@(posedge clk_sys_i) set_a);
   c_pc_turn: cover property (@(posedge clk_sys_i) is_pc && timer_tick && at_top);
   c_ext: cover property (@(posedge clk_sys_i) cfg_i.clk_sel == EBT_CS_EXT_RISE && timer_tick);
   c_ctc_wrap: cover property (@(posedge clk_sys_i) is_clear && timer_tick && at_top);

   // =========================================
   // flag and mask invariants
   a_ovf_flag_set: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      pend_ovf_reg |=> flag_reg[EBT_BIT_OVF]) else $error("overflow flag not set");
   a_ovf_rise_src: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(flag_reg[EBT_BIT_OVF]) |-> $past(pend_ovf_reg)) else $error("overflow flag without event");
   a_flag_a_rise: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(flag_reg[EBT_BIT_MA]) |-> $past(set_a)) else $error("match a flag without tick");
   a_flag_b_rise: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      $rose(flag_reg[EBT_BIT_MB]) |-> $past(set_b)) else $error("match b flag without tick");
   a_flag_a_clear: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (irq_ack_i[EBT_BIT_MA] && !set_a) |=> !flag_reg[EBT_BIT_MA]) else $error("flag a not cleared");
   a_flag_b_wclr: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (wr_i.flag_we && wr_i.wdata[EBT_BIT_MB] && !set_b) |=> !flag_reg[EBT_BIT_MB])
      else $error("flag b write clear lost");
   a_flag_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (set_vec == 3'h0 && clr_vec == 3'h0) |=> $stable(flag_reg)) else $error("flag moved idle");
   a_mask_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      wr_i.mask_we |=> mask_reg == $past(wr_i.wdata[2:0])) else $error("mask write lost");
   a_mask_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      !wr_i.mask_we |=> $stable(mask_reg)) else $error("mask moved without write");

   // =========================================
   // compare stage invariants
   // the active stage may only move at the update point in pwm modes
   a_buf_hold_pwm: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_pwm && !upd_pt) |=> $stable(act_a_reg) && $stable(act_b_reg)) else $error("active moved mid-period");
   a_buf_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_pwm && upd_pt) |=> act_a_reg == $past(buf_a_reg) && act_b_reg == $past(buf_b_reg))
      else $error("buffer not loaded");
   a_buf_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      wr_i.cmp_b_we |=> buf_b_reg == $past(wr_i.wdata)) else $error("buffer b write lost");
   a_direct_cmp_b: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!is_pwm && wr_i.cmp_b_we) |=> act_b_reg == $past(wr_i.wdata)) else $error("direct b write missing");

   // =========================================
   // counter and tick invariants
   a_stop_no_tick: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      cfg_i.clk_sel == EBT_CS_STOP |-> !timer_tick) else $error("tick while stopped");
   a_div1_tick: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      cfg_i.clk_sel == EBT_CS_DIV1 |-> timer_tick) else $error("no tick at full rate");
   a_no_tick_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!timer_tick && !wr_i.cnt_we) |=> $stable(count_value_reg)) else $error("count moved without tick");
   a_up_count: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (timer_tick && !is_pc && !wr_i.cnt_we && !((is_clear | is_fast) && at_top))
      |=> count_value_reg == $past(count_value_reg) + 8'h01) else $error("up count wrong");
   a_pc_turn_top: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_pc && timer_tick && !dir_down_reg && at_top && !wr_i.cnt_we) |=> dir_down_reg)
      else $error("no turn at top");
   a_pc_turn_bot: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_pc && timer_tick && dir_down_reg && at_bottom && !wr_i.cnt_we)
      |=> !dir_down_reg && count_value_reg == 8'h01) else $error("no turn at bottom");
   a_fast_wrap: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (is_fast && timer_tick && at_top && !wr_i.cnt_we) |=> count_value_reg == EBT_BOTTOM)
      else $error("fast pwm did not wrap");

   // =========================================
   // waveform outputs only move on a set or a tick
   a_out_a_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!set_a && !timer_tick) |=> $stable(oc_a_reg)) else $error("output a moved idle");
   a_out_b_hold: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
      (!set_b && !timer_tick) |=> $stable(oc_b_reg)) else $error("output b moved idle");
endmodule

// ==== sim/ebt_ext_src.sv ====
// far-side model: source of pulses on the external count pin
`timescale 1ns/1ps
module ebt_ext_src (
   input  wire logic       clk_sys_i,
   input  wire logic       go_i,
   input  wire logic [7:0] n_i,
   output logic            pin_o,
   output logic            busy_o
);
   // =========================================
   // pulse train
   // pin rests low; each pulse gives one rising and one falling edge
   initial begin
      pin_o  = 1'b0;
      busy_o = 1'b0;
   end
   // slow edges, well apart, so the two-flop synchroniser sees each one
   always begin
      @(posedge go_i);
      busy_o = 1'b1;
      repeat (n_i) begin
         repeat (5) @(posedge clk_sys_i);
         #3 pin_o = 1'b1;
         repeat (5) @(posedge clk_sys_i);
         #3 pin_o = 1'b0;
      end
      repeat (2) @(posedge clk_sys_i);
      busy_o = 1'b0;
   end
endmodule

// ==== sim/tb_ebt_timer.sv ====
// testbench of the 8-bit timer core: write tasks and directed tests
`timescale 1ns/1ps
module tb_ebt_timer;
   import ebt_pkg::*;
   // =========================================
   // signals
   logic            clk_sys_i;
   logic            rstn_i;
   ebt_wr_t         wr;
   ebt_cfg_t        cfg;
   logic [2:0]      ack;
   logic            pin;
   logic            go;
   logic [7:0]      n_pulse;
   logic            busy;
   logic [7:0]      count_value_o;
   logic [7:0]      cmp_a;
   logic [7:0]      cmp_b;
   logic [2:0]      flags;
   logic [2:0]      mask;
   logic [2:0]      irq;
   logic            out_a;
   logic            out_b;
   int              bad_count;
   int              tests_run;
   int              ea;
   int              eb;
   logic [7:0]      mx;
   logic [7:0]      c0;
   logic            dn;
   logic            zr;
   localparam logic [4:0] W_CNT = 5'h10;
   localparam logic [4:0] W_CA  = 5'h08;
   localparam logic [4:0] W_CB  = 5'h04;
   localparam logic [4:0] W_MSK = 5'h02;
   localparam logic [4:0] W_FLG = 5'h01;

   ebt_timer u_ebt_timer (
      .clk_sys_i            (clk_sys_i),
      .rstn_i               (rstn_i),
      .wr_i                 (wr),
      .cfg_i                (cfg),
      .irq_ack_i            (ack),
      .ext_count_pin_i      (pin),
      .count_value_o        (count_value_o),
      .compare_value_a_o    (cmp_a),
      .compare_value_b_o    (cmp_b),
      .timer_flag_reg_o     (flags),
      .timer_irq_mask_reg_o (mask),
      .irq_req_o            (irq),
      .compare_out_a_o      (out_a),
      .compare_out_b_o      (out_b)
   );
   ebt_ext_src u_ebt_ext_src (
      .clk_sys_i (clk_sys_i),
      .go_i      (go),
      .n_i       (n_pulse),
      .pin_o     (pin),
      .busy_o    (busy)
   );

   // =========================================
   // clock, tasks
   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end
   // inputs move 2 ns after the edge (the external pin 3 ns), outputs are settled by then
   task automatic step(input int n);
      repeat (n) begin
         @(posedge clk_sys_i);
         #2;
      end
   endtask
   // one-cycle strobe, dropped before any next write can raise it again
   task automatic wrt(input logic [4:0] s, input logic [7:0] d);
      wr = {s, d};
      step(1);
      wr = '0;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_flag(input int b);
      for (int i = 0; i < 300 && flags[b] !== 1'b1; i++) step(1);
   endtask
   // tracks peak, down steps, visits of zero and output edges
   task automatic scan(input int n);
      logic [7:0] prev;
      logic       pa;
      logic       pb;
      mx = 8'h00; dn = 1'b0; zr = 1'b0; ea = 0; eb = 0;
      for (int i = 0; i < n; i++) begin
         prev = count_value_o; pa = out_a; pb = out_b;
         step(1);
         if (count_value_o > mx) mx = count_value_o;
         if (count_value_o == prev - 8'h01) dn = 1'b1;
         if (count_value_o == 8'h00) zr = 1'b1;
         if (out_a !== pa) ea++;
         if (out_b !== pb) eb++;
      end
   endtask
   task automatic ext_run(input ebt_cs_t cs);
      cfg.clk_sel = cs;
      c0 = count_value_o;
      n_pulse = 8'h06; go = 1'b1;
      step(2);
      go = 1'b0;
      for (int i = 0; i < 400 && busy !== 1'b0; i++) step(1);
      step(8);
      chk("ext count", 8'h06, count_value_o - c0);
   endtask
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // hang guard: all tests take about 1750 cycles
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      bad_count++;
      end_of_test;
   end

   // =========================================
   // tests
   initial begin
      wr = '0; cfg = '0; ack = 3'h0; go = 1'b0; n_pulse = 8'h00;
      bad_count = 0; tests_run = 0; rstn_i = 1'b0;
      repeat (8) @(posedge clk_sys_i);
      #2 rstn_i = 1'b1;
      step(1);
      chk("reset count", 8'h00, count_value_o);
      chk("reset cmp", 8'h00, cmp_a | cmp_b);
      chk("reset flags", 8'h00, {2'h0, flags, mask});
      chk("reset outs", 8'h00, {5'h0, irq});
      $display("test reset done");
      // stopped source holds the count
      wrt(W_CNT, 8'h10);
      step(20);
      chk("stopped", 8'h10, count_value_o);
      cfg.clk_sel = EBT_CS_DIV1;
      step(2);
      c0 = count_value_o;
      step(10);
      chk("up by ten", 8'h0a, count_value_o - c0);
      wrt(W_CNT, 8'h80);
      chk("write wins", 8'h80, count_value_o);
      cfg.clk_sel = EBT_CS_DIV8;
      step(9);
      c0 = count_value_o;
      step(160);
      chk("div8", 8'h01, 8'((count_value_o - c0) inside {[19:21]}));
      $display("test clock done");
      // matches, masks and clearing
      cfg.clk_sel = EBT_CS_STOP;
      wrt(W_CA, 8'h20);
      wrt(W_CB, 8'h30);
      chk("direct cmp", 8'h20, cmp_a);
      chk("direct cmp b", 8'h30, cmp_b);
      wrt(W_FLG, 8'h07);
      wrt(W_CNT, 8'h20);
      wrt(W_MSK, 8'h07);
      cfg.clk_sel = EBT_CS_DIV1;
      step(10);
      chk("blocked", 8'h00, {5'h0, flags});
      wrt(W_CNT, 8'h1c);
      wait_flag(EBT_BIT_MA);
      chk("match a", 8'h22, count_value_o);
      chk("a only", 8'h02, {5'h0, irq});
      wait_flag(EBT_BIT_MB);
      chk("a and b", 8'h06, {5'h0, irq});
      wrt(W_MSK, 8'h04);
      chk("masked", 8'h04, {5'h0, irq});
      wrt(W_FLG, 8'h02);
      chk("clear a", 8'h04, {5'h0, flags});
      ack = 3'h4;
      step(1);
      ack = 3'h0;
      step(1);
      chk("ack b", 8'h00, {5'h0, flags});
      wait_flag(EBT_BIT_OVF);
      chk("overflow", 8'h01, 8'(count_value_o < 8'h03));
      ack = 3'h1;
      step(1);
      ack = 3'h0;
      step(1);
      chk("ack ovf", 8'h00, {7'h0, flags[EBT_BIT_OVF]});
      $display("test compare done");
      // clear-on-match: top is compare a
      cfg = '{EBT_CS_STOP, EBT_WM_CLEAR, EBT_CO_TOGGLE, EBT_CO_OFF};
      wrt(W_CA, 8'h05);
      wrt(W_CNT, 8'h00);
      cfg.clk_sel = EBT_CS_DIV1;
      scan(40);
      chk("ctc top", 8'h05, mx);
      chk("ctc bottom", 8'h01, 8'(zr));
      chk("ctc toggles", 8'h01, 8'(ea >= 5));
      $display("test ctc done");
      // phase-correct pwm, top 0xff, buffered compares
      cfg = '{EBT_CS_DIV1, EBT_WM_PC_MAX, EBT_CO_CLEAR, EBT_CO_SET};
      wrt(W_CA, 8'h40);
      wrt(W_CB, 8'h80);
      chk("buffer a", 8'h40, cmp_a);
      scan(1100);
      chk("pc top", 8'hff, mx);
      chk("pc down", 8'h01, 8'(dn));
      chk("pc edges", 8'h01, 8'(ea >= 2 && eb >= 2));
      $display("test pwm done");
      // external pin, both edges
      cfg = '{EBT_CS_STOP, EBT_WM_NORMAL, EBT_CO_OFF, EBT_CO_OFF};
      step(2);
      ext_run(EBT_CS_EXT_RISE);
      ext_run(EBT_CS_EXT_FALL);
      $display("test external done");
      end_of_test;
   end
endmodule
